// File: rtl/sabd_pkg.sv
package sabd_pkg;

	// Bus widths
	localparam int BANK_W  = 2;   // Bank select width
	localparam int ADDR_W  = 13;  // Multiplexed address bus width
	localparam int COL_W   = 11;  // Column address width (bits 9:0 and 11)
	localparam int DATA_W  = 8;   // Data lines width
	localparam int NBANKS  = 4;   // Bank count

	// Field positions on the address bus
	localparam int AP_BIT    = 10;  // Auto-precharge flag position
	localparam int COL_HI    = 11;  // Upper column bit position
	localparam int COL_LO_HI = 9;   // Top of the low column field

	// Reset values and bank masks
	localparam logic [ADDR_W-1:0] ROW_RST = 13'h0000;  // Row register reset
	localparam logic [COL_W-1:0]  COL_RST = 11'h000;   // Column register reset
	localparam logic [NBANKS-1:0] MASK_NONE = 4'h0;    // No bank mask
	localparam logic [NBANKS-1:0] MASK_ALL  = 4'hF;    // All banks mask

	// Decoded commands
	typedef enum logic [3:0] {
		SABD_NOP, SABD_ACT, SABD_PRE, SABD_RD, SABD_WR,
		SABD_MRS, SABD_REF, SABD_BST, SABD_DESEL
	} sabd_cmd_t;

endpackage : sabd_pkg

// File: rtl/sabd_if.sv
`timescale 1ns/1ps
`default_nettype none
// Decoded command bundle between decoder and top
interface sabd_if;
	sabd_pkg::sabd_cmd_t cmd;       // Decoded command
	logic                valid;     // Command sampled with clock enabled
	logic                dmask;     // Data mask level this edge
	modport dec (output cmd, output valid, output dmask);
	modport use_side (input cmd, input valid, input dmask);
endinterface : sabd_if
`default_nettype wire

// File: rtl/sabd_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Turns strobe levels into a command, combinationally
module sabd_cmd_decode
(
	input  wire logic i_cke,
	input  wire logic i_cs_n,
	input  wire logic i_ras_n,
	input  wire logic i_cas_n,
	input  wire logic i_we_n,
	input  wire logic i_dqm,
	sabd_if.dec       bus
);
	// Strobe truth table
	always_comb
	begin
		bus.valid = i_cke; // RULE_10
		bus.dmask = i_dqm; // RULE_08
		if (i_cs_n)
		begin
			bus.cmd = sabd_pkg::SABD_DESEL;
		end
		else
		begin
			unique case ({i_ras_n, i_cas_n, i_we_n}) // RULE_09
				3'h0: bus.cmd = sabd_pkg::SABD_MRS;
				3'h1: bus.cmd = sabd_pkg::SABD_REF;
				3'h2: bus.cmd = sabd_pkg::SABD_PRE;
				3'h3: bus.cmd = sabd_pkg::SABD_ACT;
				3'h4: bus.cmd = sabd_pkg::SABD_WR;
				3'h5: bus.cmd = sabd_pkg::SABD_RD;
				3'h6: bus.cmd = sabd_pkg::SABD_BST;
				3'h7: bus.cmd = sabd_pkg::SABD_NOP;
			endcase
		end
	end
endmodule : sabd_cmd_decode
`default_nettype wire

// File: rtl/sabd_top.sv
// Behaviour
// RULE_01 - Bank commands act on selected bank only
// RULE_02 - Activate captures all thirteen bits as row
// RULE_03 - Column from bits 9:0 and 11
// RULE_04 - Flag high: precharge bank after burst
// RULE_05 - Flag low: bank stays open after burst
// RULE_06 - Precharge with flag high closes all banks
// RULE_07 - Precharge with flag low closes one bank
// RULE_08 - One mask gates all eight data lines
// RULE_09 - Commands decoded from strobes at rising edge
// RULE_10 - Clock enable low freezes command sampling
`timescale 1ns/1ps
`default_nettype none
module sabd_top
#(
	parameter int BURST_LEN = 4  // Beats per burst before auto-precharge
)
(
	input  wire logic                           i_clock,
	input  wire logic                           i_rstn,
	input  wire logic                           i_cke,
	input  wire logic                           i_cs_n,
	input  wire logic                           i_ras_n,
	input  wire logic                           i_cas_n,
	input  wire logic                           i_we_n,
	input  wire logic                           i_dqm,
	input  wire logic [sabd_pkg::BANK_W-1:0]    i_bank_select,
	input  wire logic [sabd_pkg::ADDR_W-1:0]    i_multiplexed_address_bus,
	input  wire logic [sabd_pkg::DATA_W-1:0]    i_data_lines,
	input  wire logic [sabd_pkg::DATA_W-1:0]    i_rd_data,
	output logic      [sabd_pkg::DATA_W-1:0]    o_data_lines,
	output logic                                o_data_lines_oe,
	output logic      [sabd_pkg::NBANKS-1:0]    o_bank_open,
	output logic      [sabd_pkg::ADDR_W-1:0]    o_row_addr,
	output logic      [sabd_pkg::COL_W-1:0]     o_col_addr,
	output logic      [sabd_pkg::BANK_W-1:0]    o_bank,
	output logic                                o_wr_en,
	output logic      [sabd_pkg::DATA_W-1:0]    o_wr_data,
	output logic                                o_rd_en,
	output logic      [sabd_pkg::NBANKS-1:0]    o_precharge
);

	sabd_if cmd_bus ();  // Decoded command bundle

	// Strobe decoder
	sabd_cmd_decode u_dec
	(
		.i_cke   (i_cke),
		.i_cs_n  (i_cs_n),
		.i_ras_n (i_ras_n),
		.i_cas_n (i_cas_n),
		.i_we_n  (i_we_n),
		.i_dqm   (i_dqm),
		.bus     (cmd_bus)
	);

	typedef enum logic [1:0] {SABD_IDLE, SABD_RBURST, SABD_WBURST} sabd_burst_t;

	localparam logic [7:0] LAST_BEAT = 8'(BURST_LEN - 1);  // Final beat count

	logic                          live;       // Command taken this edge
	logic                          ap;         // Auto-precharge flag
	logic [sabd_pkg::NBANKS-1:0]   sel_onehot; // Selected bank one-hot
	logic [sabd_pkg::COL_W-1:0]    col;        // Column from address bus
	logic [sabd_pkg::NBANKS-1:0]   pre_mask;   // Banks to close this edge
	logic                          burst_end;  // Last beat of a burst
	sabd_burst_t                   burst_ff;   // Burst state
	logic [7:0]                    beat_ff;    // Beat counter
	logic                          ap_pend_ff; // Auto-precharge pending
	logic [sabd_pkg::BANK_W-1:0]   ap_bank_ff; // Bank owed a precharge
	logic [sabd_pkg::NBANKS-1:0]   open_ff;    // Open bank map

	assign live = cmd_bus.valid; // RULE_10
	assign ap   = i_multiplexed_address_bus[sabd_pkg::AP_BIT];
	assign sel_onehot = sabd_pkg::NBANKS'(1) << i_bank_select; // RULE_01
	assign col = {i_multiplexed_address_bus[sabd_pkg::COL_HI],
		i_multiplexed_address_bus[sabd_pkg::COL_LO_HI:0]}; // RULE_03
	assign burst_end = (burst_ff != SABD_IDLE) && (beat_ff >= LAST_BEAT) && i_cke;

	// Banks to precharge this edge: command or burst end
	always_comb
	begin
		pre_mask = sabd_pkg::MASK_NONE;
		if (burst_end && ap_pend_ff)
		begin
			pre_mask = sabd_pkg::NBANKS'(1) << ap_bank_ff; // RULE_04
		end
		if (live && cmd_bus.cmd == sabd_pkg::SABD_PRE)
		begin
			if (ap)
			begin
				pre_mask = sabd_pkg::MASK_ALL; // RULE_06
			end
			else
			begin
				pre_mask = pre_mask | sel_onehot; // RULE_07
			end
		end
	end

	// Row capture on activate
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_row_addr <= sabd_pkg::ROW_RST;
		end
		else if (live && cmd_bus.cmd == sabd_pkg::SABD_ACT)
		begin
			o_row_addr <= i_multiplexed_address_bus; // RULE_02
		end
	end

	// Column and bank capture on read, write or activate
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_col_addr <= sabd_pkg::COL_RST;
			o_bank     <= '0;
		end
		else if (live && (cmd_bus.cmd == sabd_pkg::SABD_RD ||
			cmd_bus.cmd == sabd_pkg::SABD_WR || cmd_bus.cmd == sabd_pkg::SABD_ACT))
		begin
			o_col_addr <= col; // RULE_03
			o_bank     <= i_bank_select; // RULE_01
		end
	end

	// Burst tracking and auto-precharge bookkeeping
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			burst_ff   <= SABD_IDLE;
			beat_ff    <= 8'h00;
			ap_pend_ff <= 1'b0;
			ap_bank_ff <= '0;
		end
		else if (live && (cmd_bus.cmd == sabd_pkg::SABD_RD ||
			cmd_bus.cmd == sabd_pkg::SABD_WR))
		begin
			// New column command restarts the burst
			burst_ff   <= (cmd_bus.cmd == sabd_pkg::SABD_RD) ? SABD_RBURST : SABD_WBURST;
			// Write command edge already carries the first beat of the burst
			beat_ff    <= (cmd_bus.cmd == sabd_pkg::SABD_WR) ? 8'h01 : 8'h00;
			ap_pend_ff <= ap; // RULE_04 RULE_05
			ap_bank_ff <= i_bank_select;
		end
		else if (live && cmd_bus.cmd == sabd_pkg::SABD_BST)
		begin
			burst_ff   <= SABD_IDLE;
			ap_pend_ff <= 1'b0;
		end
		else if (burst_end)
		begin
			burst_ff   <= SABD_IDLE;
			ap_pend_ff <= 1'b0;
		end
		else if (burst_ff != SABD_IDLE && i_cke)
		begin
			beat_ff <= beat_ff + 8'h01;
		end
	end

	// Open bank map
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			open_ff <= sabd_pkg::MASK_NONE;
		end
		else
		begin
			open_ff <= (open_ff & ~pre_mask) |
				((live && cmd_bus.cmd == sabd_pkg::SABD_ACT) ? sel_onehot
				: sabd_pkg::MASK_NONE); // RULE_01 RULE_05
		end
	end

	// Precharge pulse out
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_precharge <= sabd_pkg::MASK_NONE;
		end
		else
		begin
			o_precharge <= pre_mask; // RULE_06 RULE_07
		end
	end

	// Write beat to core, one mask for all lines
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_wr_en   <= 1'b0;
			o_wr_data <= '0;
		end
		else
		begin
			o_wr_en   <= i_cke && !cmd_bus.dmask && ((live && cmd_bus.cmd ==
				sabd_pkg::SABD_WR) || burst_ff == SABD_WBURST); // RULE_08
			o_wr_data <= i_data_lines;
		end
	end

	// Read beat request and data line drive
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_rd_en         <= 1'b0;
			o_data_lines    <= '0;
			o_data_lines_oe <= 1'b0;
		end
		else
		begin
			o_rd_en         <= i_cke && burst_ff == SABD_RBURST;
			o_data_lines    <= i_rd_data;
			o_data_lines_oe <= i_cke && !cmd_bus.dmask && burst_ff == SABD_RBURST; // RULE_08
		end
	end

	assign o_bank_open = open_ff;

	ap_close_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(live && cmd_bus.cmd == sabd_pkg::SABD_PRE && ap) |=> o_precharge == 4'hF)
		else $error("precharge all missed"); // RULE_06
	one_close_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(live && cmd_bus.cmd == sabd_pkg::SABD_PRE && !ap && !burst_end)
		|=> o_precharge == $past(sel_onehot))
		else $error("single precharge wrong"); // RULE_07
	row_cap_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(live && cmd_bus.cmd == sabd_pkg::SABD_ACT)
		|=> o_row_addr == $past(i_multiplexed_address_bus))
		else $error("row not captured"); // RULE_02
	col_cap_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(live && cmd_bus.cmd == sabd_pkg::SABD_RD) |=> o_col_addr == $past(col))
		else $error("column not captured"); // RULE_03
	act_open_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(live && cmd_bus.cmd == sabd_pkg::SABD_ACT) |=> (o_bank_open & $past(sel_onehot)) != 0)
		else $error("bank not opened"); // RULE_01
	auto_pre_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(burst_end && ap_pend_ff) |=> o_precharge[$past(ap_bank_ff)])
		else $error("auto precharge missed"); // RULE_04
	no_auto_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(burst_end && !ap_pend_ff && !(live && cmd_bus.cmd == sabd_pkg::SABD_PRE))
		|=> o_precharge == 4'h0)
		else $error("unwanted precharge"); // RULE_05
	mask_wr_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_dqm |=> !o_wr_en && !o_data_lines_oe)
		else $error("masked beat moved data"); // RULE_08
	cke_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!i_cke |=> $stable(o_row_addr) && !o_wr_en && !o_rd_en)
		else $error("cke low still sampled"); // RULE_10
	dec_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(!i_cs_n && !i_ras_n && i_cas_n && i_we_n) |-> cmd_bus.cmd == sabd_pkg::SABD_ACT)
		else $error("decode wrong"); // RULE_09

endmodule : sabd_top
`default_nettype wire

// File: test/sabd_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller model: one command per falling edge
module sabd_ctrl_model
(
	input  wire logic        i_clock,
	output logic             o_cke,
	output logic             o_cs_n,
	output logic             o_ras_n,
	output logic             o_cas_n,
	output logic             o_we_n,
	output logic             o_dqm,
	output logic [1:0]       o_bank,
	output logic [12:0]      o_addr,
	output logic [7:0]       o_data
);
	// Deselected, clock enabled at time zero
	initial
	begin
		{o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n, o_dqm} = 6'h3E;
		o_bank = 2'h0;
		o_addr = 13'h0000;
		o_data = 8'h00;
	end
	// Strobes s are {cs, ras, cas, we}, all held until the next command
	task automatic send(input logic [3:0] s, input logic [1:0] b,
		input logic [12:0] a, input logic m, input logic ce, input logic [7:0] d);
		@(negedge i_clock);
		o_cke = ce;
		{o_cs_n, o_ras_n, o_cas_n, o_we_n} = s;
		o_bank = b;
		o_addr = a;
		o_dqm = m;
		o_data = d;
	endtask : send
	// Deselect; released lines show inverted values, not stale ones
	task automatic idle();
		send(4'hF, ~o_bank, ~o_addr, 1'b0, 1'b1, ~o_data);
	endtask : idle
endmodule : sabd_ctrl_model
`default_nettype wire

// File: test/test_sdram_address_bank_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_sdram_address_bank_decode;
	localparam int P_BURST = 4;  // Beats per burst
	logic        clock;          // 200 MHz clock
	logic        rstn;           // Active-low reset
	logic [7:0]  rd_data;        // Core read data
	wire         cke, cs_n, ras_n, cas_n, we_n, dqm;
	wire  [1:0]  bank;
	wire  [12:0] addr;
	wire  [7:0]  data, o_data_lines, o_wr_data;
	logic        o_data_lines_oe, o_wr_en, o_rd_en;
	logic [3:0]  o_bank_open, o_precharge;
	logic [12:0] o_row_addr, row;
	logic [10:0] o_col_addr, col;
	logic [1:0]  o_bank;
	logic [7:0]  d [4];          // Write beats
	logic [7:0]  wr_q [$];       // Expected write data
	logic [3:0]  pre_q [$];      // Expected precharge maps
	int          error_cnt, comparisons, seed, cycles, rd_cnt, oe_cnt;

	sabd_ctrl_model sabd_ctrl_model_inst (.i_clock(clock), .o_cke(cke), .o_cs_n(cs_n),
		.o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_dqm(dqm), .o_bank(bank),
		.o_addr(addr), .o_data(data));
	sabd_top #(.BURST_LEN(P_BURST)) sabd_top_inst (.i_clock(clock), .i_rstn(rstn),
		.i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
		.i_dqm(dqm), .i_bank_select(bank), .i_multiplexed_address_bus(addr),
		.i_data_lines(data), .i_rd_data(rd_data), .o_data_lines(o_data_lines),
		.o_data_lines_oe(o_data_lines_oe), .o_bank_open(o_bank_open),
		.o_row_addr(o_row_addr), .o_col_addr(o_col_addr), .o_bank(o_bank),
		.o_wr_en(o_wr_en), .o_wr_data(o_wr_data), .o_rd_en(o_rd_en),
		.o_precharge(o_precharge));

	// Free-running clock
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Compare one value and count it
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Counts, verdict and end of run
	task automatic finish_test();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	// Random core read data each falling edge
	always @(negedge clock)
		rd_data <= 8'($random(seed));
	// Watcher: pops the oldest note whenever a precharge or write result shows
	always @(negedge clock)
	begin
		if (rstn && o_precharge !== 4'h0)
			check("precharge", pre_q.size() ? pre_q.pop_front() : 4'h0, o_precharge);
		if (rstn && o_wr_en !== 1'b0)
			check("wr_data", wr_q.size() ? wr_q.pop_front() : 8'h00, o_wr_data);
		// Driven read data is the core data sampled at the last rising edge
		if (rstn && o_data_lines_oe === 1'b1)
			check("rd_data", rd_data, o_data_lines);
		rd_cnt += int'(o_rd_en === 1'b1);
		oe_cnt += int'(o_data_lines_oe === 1'b1);
	end
	// Main sequence
	initial
	begin
		{error_cnt, comparisons, cycles, rd_cnt, oe_cnt} = '0;
		seed = 35088;
		rstn = 1'b0;
		rd_data = 8'h00;
		repeat (10) @(posedge clock);
		@(negedge clock) rstn = 1'b1;
		check("open after reset", 16'h0, o_bank_open);
		// Open every bank with a random row
		for (int b = 0; b < 4; b++)
		begin
			row = 13'($random(seed));
			sabd_ctrl_model_inst.send(4'h3, 2'(b), row, 1'b0, 1'b1, 8'h00);
			sabd_ctrl_model_inst.idle();
			check("row", 16'(row), 16'(o_row_addr));
			check("bank", 16'(b), 16'(o_bank));
		end
		check("open all", 16'hF, o_bank_open);
		// Write with auto-precharge, third beat masked
		col = 11'($random(seed));
		for (int i = 0; i < 4; i++)
			d[i] = 8'($random(seed));
		sabd_ctrl_model_inst.send(4'h4, 2'h2, {1'b0, col[10], 1'b1, col[9:0]}, 1'b0, 1'b1, d[0]);
		wr_q.push_back(d[0]);
		for (int i = 1; i < P_BURST; i++)
		begin
			sabd_ctrl_model_inst.send(4'h7, 2'h0, 13'h0000, i == 2, 1'b1, d[i]);
			if (i != 2)
				wr_q.push_back(d[i]);
		end
		pre_q.push_back(4'h4);
		check("col", 16'(col), 16'(o_col_addr));
		repeat (4) sabd_ctrl_model_inst.idle();
		check("open after auto", 16'hB, o_bank_open);
		// Read without auto-precharge
		{rd_cnt, oe_cnt} = '0;
		sabd_ctrl_model_inst.send(4'h5, 2'h1, {2'h0, 1'b0, 10'h3FF}, 1'b0, 1'b1, 8'h00);
		repeat (8) sabd_ctrl_model_inst.idle();
		check("read beats", 16'(P_BURST), 16'(rd_cnt));
		check("read drive", 16'(P_BURST), 16'(oe_cnt));
		check("open after read", 16'hB, o_bank_open);
		// Single-bank then all-bank precharge
		pre_q.push_back(4'h8);
		sabd_ctrl_model_inst.send(4'h2, 2'h3, 13'h1BFF, 1'b0, 1'b1, 8'h00);
		repeat (2) sabd_ctrl_model_inst.idle();
		check("open after pre", 16'h3, o_bank_open);
		pre_q.push_back(4'hF);
		sabd_ctrl_model_inst.send(4'h2, 2'($random(seed)), 13'h0400, 1'b0, 1'b1, 8'h00);
		repeat (2) sabd_ctrl_model_inst.idle();
		check("open after pre all", 16'h0, o_bank_open);
		// Activate refused with clock gated, then with chip deselected
		sabd_ctrl_model_inst.send(4'h3, 2'h0, 13'h0123, 1'b0, 1'b0, 8'h00);
		sabd_ctrl_model_inst.idle();
		check("open gated", 16'h0, o_bank_open);
		sabd_ctrl_model_inst.send(4'hB, 2'h0, 13'h0123, 1'b0, 1'b1, 8'h00);
		sabd_ctrl_model_inst.idle();
		check("open deselected", 16'h0, o_bank_open);
		sabd_ctrl_model_inst.send(4'h3, 2'h0, 13'h0123, 1'b0, 1'b1, 8'h00);
		sabd_ctrl_model_inst.idle();
		check("open taken", 16'h1, o_bank_open);
		// Read with auto-precharge cut by burst stop: one beat, bank stays open
		{rd_cnt, oe_cnt} = '0;
		sabd_ctrl_model_inst.send(4'h5, 2'h0, 13'h0400, 1'b0, 1'b1, 8'h00);
		sabd_ctrl_model_inst.send(4'h6, 2'h0, 13'h0000, 1'b0, 1'b1, 8'h00);
		repeat (6) sabd_ctrl_model_inst.idle();
		check("beats before stop", 16'h1, 16'(rd_cnt));
		check("open after stop", 16'h1, o_bank_open);
		check("pending", 16'h0, 16'(wr_q.size() + pre_q.size()));
		finish_test();
	end
endmodule : test_sdram_address_bank_decode
`default_nettype wire
